// ==== verilog/dmfc_defines.svh ====
`ifndef DMFC_DEFINES_SVH
`define DMFC_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define DMFC_OFS_CTRL 8'h00
`define DMFC_OFS_MSG 8'h04
`define DMFC_OFS_STAT 8'h08
`define DMFC_OFS_TUN 8'h0C
`define DMFC_OFS_MACLO 8'h10
`define DMFC_OFS_MACHI 8'h14
`define DMFC_OFS_SRCIP 8'h18
`define DMFC_OFS_SRCMSK 8'h1C
`define DMFC_OFS_DSTIP 8'h20
`define DMFC_OFS_PORTS 8'h24
`define DMFC_OFS_TIMER 8'h28
`define DMFC_OFS_UCN 8'h2C

// ****************************************************************
// Field positions
// ****************************************************************
`define DMFC_CTRL_MODE 1:0
`define DMFC_CTRL_BREQ 2
`define DMFC_CTRL_MACN 7:4
`define DMFC_MSG_TYPE 7:0
`define DMFC_MSG_PARAM 15:8
`define DMFC_MSG_REC 16
`define DMFC_TIMER_VAL 15:0
`define DMFC_TIMER_MAP 23:16

// ****************************************************************
// Message framing and codes
// ****************************************************************
`define DMFC_MSG_TAG 24'h9F9103
`define DMFC_T_TWOWAY 8'h01
`define DMFC_T_ONEWAY 8'h02
`define DMFC_T_SCAN 8'h03
`define DMFC_T_CHG 8'h04
`define DMFC_T_RESET 8'h05
`define DMFC_T_BADMAC 8'h06
`define DMFC_T_FWDLIM 8'h07
`define DMFC_INIT_MAX 8'h05
`define DMFC_FWD_MAX 8'h01
`define DMFC_MACN_MIN 4'h1
`define DMFC_MACN_MAX 4'h8
`define DMFC_LEN_SHORT 8'h01
`define DMFC_LEN_LONG 8'h02
`define DMFC_CNT_SHORT 5'h05
`define DMFC_CNT_LONG 5'h06
`define DMFC_CNT_REC 5'h18

// ****************************************************************
// Timing
// ****************************************************************
`define DMFC_TIMER_UNIT_NS 1000000000
`define DMFC_CLK_PERIOD_NS 4
`define DMFC_SEC_CYCLES (`DMFC_TIMER_UNIT_NS / `DMFC_CLK_PERIOD_NS)

`endif

// ==== verilog/dmfc_pkg.sv ====
package dmfc_pkg;

    // Operational mode as written by software
    typedef enum logic [1:0]
    {
        DMFC_MODE_OFF,
        DMFC_MODE_ADV_TWO,
        DMFC_MODE_ADV_ONE,
        DMFC_MODE_BASIC
    } dmfc_mode_e;

    // Byte serialiser state
    typedef enum logic
    {
        DMFC_TX_IDLE,
        DMFC_TX_SEND
    } dmfc_tx_e;

endpackage

// ==== verilog/dmfc_filt_if.sv ====
`timescale 1ns/1ps

// Filter record plus packet header, shared by top and matcher
interface dmfc_filt_if;
    logic [47:0] rec_mac;
    logic [31:0] src_ip_match;
    logic [31:0] src_ip_wildcard;
    logic [31:0] dst_ip_match;
    logic [15:0] port_start;
    logic [15:0] port_end;
    logic pkt_valid;
    logic pkt_is_udp;
    logic [47:0] pkt_mac;
    logic [31:0] pkt_src_ip;
    logic [31:0] pkt_dst_ip;
    logic [15:0] pkt_dst_port;
    logic hit;

    modport top (output rec_mac, src_ip_match, src_ip_wildcard,
        dst_ip_match, port_start, port_end, pkt_valid, pkt_is_udp,
        pkt_mac, pkt_src_ip, pkt_dst_ip, pkt_dst_port, input hit);
    modport filt (input rec_mac, src_ip_match, src_ip_wildcard,
        dst_ip_match, port_start, port_end, pkt_valid, pkt_is_udp,
        pkt_mac, pkt_src_ip, pkt_dst_ip, pkt_dst_port, output hit);
endinterface

// ==== verilog/dmfc_filter.sv ====
`timescale 1ns/1ps

// Combinational match of one packet header against the tunnel filter
module dmfc_filter
(
    dmfc_filt_if.filt f
);
    logic src_ok;
    logic dst_ok;
    logic port_ok;

    // Zero address is a wildcard; mask selects compared source bits
    always_comb
    begin
        src_ok = (f.src_ip_match == 32'h00000000) ||
            ((f.pkt_src_ip & f.src_ip_wildcard) ==
             (f.src_ip_match & f.src_ip_wildcard));
        dst_ok = (f.dst_ip_match == 32'h00000000) ||
            (f.pkt_dst_ip == f.dst_ip_match);
    end

    // Inclusive range, UDP only
    assign port_ok = f.pkt_is_udp && (f.pkt_dst_port >= f.port_start) &&
        (f.pkt_dst_port <= f.port_end);

    assign f.hit = f.pkt_valid && (f.pkt_mac == f.rec_mac) && src_ok &&
        dst_ok && port_ok;
endmodule

// ==== verilog/dmfc_codec.sv ====
`timescale 1ns/1ps
`include "dmfc_defines.svh"

module dmfc_codec
    import dmfc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `DMFC_SEC_CYCLES
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    input wire logic op_timeout,
    output logic scan_start,
    input wire logic pkt_valid,
    input wire logic pkt_is_udp,
    input wire logic [47:0] pkt_mac,
    input wire logic [31:0] pkt_src_ip,
    input wire logic [31:0] pkt_dst_ip,
    input wire logic [15:0] pkt_dst_port,
    output logic pkt_match,
    output logic [7:0] match_tunnel,
    output logic [7:0] channel_map_selector,
    output logic basic_mode
);
    // ********************
    // Registers
    // ********************
    dmfc_mode_e mode_reg;
    logic [7:0] tunnel_number_reg;
    logic [7:0] tunnel_prio_reg;
    logic [47:0] mac_reg;
    logic [31:0] src_ip_match_reg;
    logic [31:0] src_ip_wildcard_reg;
    logic [31:0] dst_ip_match_reg;
    logic [15:0] port_start_reg;
    logic [15:0] port_end_reg;
    logic [15:0] oneway_rescan_timer_reg;
    logic [7:0] map_reg;
    logic [7:0] upstream_channel_number_reg;
    logic chg_pend_reg;
    logic reinit_pend_reg;
    logic oneway_reg;
    logic fwd_lim_reg;
    logic basic_ok_reg;
    logic basic_bad_reg;
    logic badmac_pend_reg;
    logic wr_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_mux;
    logic addr_ok;

    // ********************
    // Bus slave
    // ********************
    // Zero wait states; only the low address byte is decoded
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign addr_ok = hsel && htrans[1] && hready;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_reg <= 1'b0;
            addr_reg <= 8'h00;
        end
        else
        begin
            wr_reg <= addr_ok && hwrite;
            addr_reg <= haddr[7:0];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (haddr[7:0])
            `DMFC_OFS_CTRL: rd_mux = {30'h00000000, mode_reg};
            `DMFC_OFS_STAT: rd_mux = {24'h000000, basic_bad_reg,
                basic_ok_reg, fwd_lim_reg, oneway_reg, reinit_pend_reg,
                chg_pend_reg, badmac_pend_reg, tx_valid};
            `DMFC_OFS_TUN: rd_mux = {16'h0000, tunnel_prio_reg,
                tunnel_number_reg};
            `DMFC_OFS_MACLO: rd_mux = mac_reg[31:0];
            `DMFC_OFS_MACHI: rd_mux = {16'h0000, mac_reg[47:32]};
            `DMFC_OFS_SRCIP: rd_mux = src_ip_match_reg;
            `DMFC_OFS_SRCMSK: rd_mux = src_ip_wildcard_reg;
            `DMFC_OFS_DSTIP: rd_mux = dst_ip_match_reg;
            `DMFC_OFS_PORTS: rd_mux = {port_start_reg, port_end_reg};
            `DMFC_OFS_TIMER: rd_mux = {8'h00, map_reg,
                oneway_rescan_timer_reg};
            `DMFC_OFS_UCN: rd_mux = {24'h000000,
                upstream_channel_number_reg};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Read data registered at the address phase, stands in data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_reg <= 32'h00000000;
        else if (addr_ok && !hwrite)
            hrdata_reg <= rd_mux;
    end

    // Mode, filter record and timer registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_reg <= DMFC_MODE_OFF;
            tunnel_number_reg <= 8'h00;
            tunnel_prio_reg <= 8'h00;
            mac_reg <= 48'h000000000000;
            src_ip_match_reg <= 32'h00000000;
            src_ip_wildcard_reg <= 32'hFFFFFFFF;
            dst_ip_match_reg <= 32'h00000000;
            port_start_reg <= 16'h0000;
            port_end_reg <= 16'hFFFF;
            oneway_rescan_timer_reg <= 16'h0000;
            map_reg <= 8'h00;
        end
        else if (wr_reg)
        begin
            unique case (addr_reg)
                `DMFC_OFS_CTRL:
                    mode_reg <= dmfc_mode_e'(hwdata[`DMFC_CTRL_MODE]);
                `DMFC_OFS_TUN:
                begin
                    tunnel_number_reg <= hwdata[7:0];
                    tunnel_prio_reg <= hwdata[15:8];
                end
                `DMFC_OFS_MACLO: mac_reg[31:0] <= hwdata;
                `DMFC_OFS_MACHI: mac_reg[47:32] <= hwdata[15:0];
                `DMFC_OFS_SRCIP: src_ip_match_reg <= hwdata;
                `DMFC_OFS_SRCMSK: src_ip_wildcard_reg <= hwdata;
                `DMFC_OFS_DSTIP: dst_ip_match_reg <= hwdata;
                `DMFC_OFS_PORTS:
                begin
                    port_start_reg <= hwdata[31:16];
                    port_end_reg <= hwdata[15:0];
                end
                `DMFC_OFS_TIMER:
                begin
                    oneway_rescan_timer_reg <= hwdata[`DMFC_TIMER_VAL];
                    map_reg <= hwdata[`DMFC_TIMER_MAP];
                end
                default: ;
            endcase
        end
    end

    assign channel_map_selector = map_reg;

    // ********************
    // Message command decode
    // ********************
    dmfc_tx_e tx_state_reg;
    logic [191:0] tx_buf_reg;
    logic [4:0] tx_cnt_reg;
    logic adv_mode;
    logic msg_wr;
    logic [7:0] m_type;
    logic [7:0] m_param;
    logic type_ok;
    logic send_ok;
    logic rec_go;
    logic badmac_go;
    logic breq_wr;
    logic macn_ok;

    assign adv_mode = (mode_reg == DMFC_MODE_ADV_TWO) ||
        (mode_reg == DMFC_MODE_ADV_ONE);
    assign msg_wr = wr_reg && (addr_reg == `DMFC_OFS_MSG);
    assign m_type = hwdata[`DMFC_MSG_TYPE];
    assign m_param = hwdata[`DMFC_MSG_PARAM];
    assign breq_wr = wr_reg && (addr_reg == `DMFC_OFS_CTRL) &&
        hwdata[`DMFC_CTRL_BREQ];
    assign macn_ok = (hwdata[`DMFC_CTRL_MACN] >= `DMFC_MACN_MIN) &&
        (hwdata[`DMFC_CTRL_MACN] <= `DMFC_MACN_MAX);

    // Reserved types and reserved codes are refused outright
    always_comb
    begin
        type_ok = 1'b0;
        unique case (m_type)
            `DMFC_T_TWOWAY, `DMFC_T_ONEWAY, `DMFC_T_SCAN,
            `DMFC_T_RESET, `DMFC_T_BADMAC: type_ok = 1'b1;
            `DMFC_T_CHG: type_ok = (m_param <= `DMFC_INIT_MAX);
            `DMFC_T_FWDLIM: type_ok = (m_param <= `DMFC_FWD_MAX);
            default: type_ok = 1'b0;
        endcase
    end

    // A message written while busy or outside advanced mode is dropped; a record dump is dropped only while busy
    assign send_ok = msg_wr && !hwdata[`DMFC_MSG_REC] && type_ok &&
        adv_mode && (tx_state_reg == DMFC_TX_IDLE);
    assign rec_go = msg_wr && hwdata[`DMFC_MSG_REC] &&
        (tx_state_reg == DMFC_TX_IDLE);
    assign badmac_go = badmac_pend_reg && !msg_wr && adv_mode &&
        (tx_state_reg == DMFC_TX_IDLE);

    // Event flags; the type 01 message closes pending changes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            upstream_channel_number_reg <= 8'h00;
            chg_pend_reg <= 1'b0;
            reinit_pend_reg <= 1'b0;
            oneway_reg <= 1'b0;
            fwd_lim_reg <= 1'b0;
        end
        else if (send_ok)
        begin
            unique case (m_type)
                `DMFC_T_TWOWAY:
                begin
                    upstream_channel_number_reg <= m_param;
                    chg_pend_reg <= 1'b0;
                    reinit_pend_reg <= 1'b0;
                    oneway_reg <= 1'b0;
                end
                `DMFC_T_ONEWAY: oneway_reg <= 1'b1;
                `DMFC_T_CHG: chg_pend_reg <= 1'b1;
                `DMFC_T_RESET: reinit_pend_reg <= 1'b1;
                `DMFC_T_FWDLIM: fwd_lim_reg <= 1'b1;
                default: ;
            endcase
        end
    end

    // Basic request: a bad count refuses basic mode and queues type 06
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            basic_ok_reg <= 1'b0;
            basic_bad_reg <= 1'b0;
            badmac_pend_reg <= 1'b0;
        end
        else if (breq_wr)
        begin
            basic_ok_reg <= macn_ok;
            basic_bad_reg <= !macn_ok;
            badmac_pend_reg <= !macn_ok ||
                (badmac_pend_reg && !badmac_go);
        end
        else if (badmac_go)
            badmac_pend_reg <= 1'b0;
    end

    assign basic_mode = basic_ok_reg;

    // ********************
    // Byte serialiser
    // ********************
    logic has_param;

    assign has_param = (m_type == `DMFC_T_TWOWAY) ||
        (m_type == `DMFC_T_CHG) || (m_type == `DMFC_T_FWDLIM);

    // Frames are left-aligned and shifted out a byte at a time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_state_reg <= DMFC_TX_IDLE;
            tx_buf_reg <= 192'h0;
            tx_cnt_reg <= 5'h00;
        end
        else
        begin
            unique case (tx_state_reg)
                DMFC_TX_IDLE:
                begin
                    if (rec_go)
                    begin
                        tx_buf_reg <= {tunnel_number_reg, tunnel_prio_reg,
                            mac_reg, src_ip_match_reg, src_ip_wildcard_reg,
                            dst_ip_match_reg, port_start_reg,
                            port_end_reg};
                        tx_cnt_reg <= `DMFC_CNT_REC;
                        tx_state_reg <= DMFC_TX_SEND;
                    end
                    else if (send_ok)
                    begin
                        tx_buf_reg <= {`DMFC_MSG_TAG,
                            has_param ? `DMFC_LEN_LONG : `DMFC_LEN_SHORT,
                            m_type, m_param, 144'h0};
                        tx_cnt_reg <= has_param ? `DMFC_CNT_LONG :
                            `DMFC_CNT_SHORT;
                        tx_state_reg <= DMFC_TX_SEND;
                    end
                    else if (badmac_go)
                    begin
                        tx_buf_reg <= {`DMFC_MSG_TAG, `DMFC_LEN_SHORT,
                            `DMFC_T_BADMAC, 152'h0};
                        tx_cnt_reg <= `DMFC_CNT_SHORT;
                        tx_state_reg <= DMFC_TX_SEND;
                    end
                end
                DMFC_TX_SEND:
                begin
                    if (tx_ready)
                    begin
                        tx_buf_reg <= {tx_buf_reg[183:0], 8'h00};
                        tx_cnt_reg <= tx_cnt_reg - 5'h01;
                        if (tx_cnt_reg == 5'h01)
                            tx_state_reg <= DMFC_TX_IDLE;
                    end
                end
            endcase
        end
    end

    assign tx_data = tx_buf_reg[191:184];
    assign tx_valid = (tx_state_reg == DMFC_TX_SEND);
    assign tx_last = tx_valid && (tx_cnt_reg == 5'h01);

    // ********************
    // One-way rescan timer
    // ********************
    logic armed_reg;
    logic [27:0] sec_cnt_reg;
    logic [15:0] rescan_cnt_reg;
    logic scan_reg;

    // Zero starts the scan at once; otherwise count whole seconds
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            armed_reg <= 1'b0;
            sec_cnt_reg <= 28'h0000000;
            rescan_cnt_reg <= 16'h0000;
            scan_reg <= 1'b0;
        end
        else
        begin
            scan_reg <= 1'b0;
            if (op_timeout)
            begin
                scan_reg <= (oneway_rescan_timer_reg == 16'h0000);
                armed_reg <= (oneway_rescan_timer_reg != 16'h0000);
                rescan_cnt_reg <= oneway_rescan_timer_reg;
                sec_cnt_reg <= 28'(SEC_CYCLES - 1);
            end
            else if (armed_reg)
            begin
                if (sec_cnt_reg != 28'h0000000)
                    sec_cnt_reg <= sec_cnt_reg - 28'h0000001;
                else if (rescan_cnt_reg == 16'h0001)
                begin
                    scan_reg <= 1'b1;
                    armed_reg <= 1'b0;
                end
                else
                begin
                    rescan_cnt_reg <= rescan_cnt_reg - 16'h0001;
                    sec_cnt_reg <= 28'(SEC_CYCLES - 1);
                end
            end
        end
    end

    assign scan_start = scan_reg;

    // ********************
    // Packet filter
    // ********************
    dmfc_filt_if fi ();
    logic match_reg;

    assign fi.rec_mac = mac_reg;
    assign fi.src_ip_match = src_ip_match_reg;
    assign fi.src_ip_wildcard = src_ip_wildcard_reg;
    assign fi.dst_ip_match = dst_ip_match_reg;
    assign fi.port_start = port_start_reg;
    assign fi.port_end = port_end_reg;
    assign fi.pkt_valid = pkt_valid;
    assign fi.pkt_is_udp = pkt_is_udp;
    assign fi.pkt_mac = pkt_mac;
    assign fi.pkt_src_ip = pkt_src_ip;
    assign fi.pkt_dst_ip = pkt_dst_ip;
    assign fi.pkt_dst_port = pkt_dst_port;

    dmfc_filter u_filter
    (
        .f(fi.filt)
    );

    // Match result registered one cycle after the header
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            match_reg <= 1'b0;
        else
            match_reg <= fi.hit;
    end

    assign pkt_match = match_reg;
    assign match_tunnel = tunnel_number_reg;
endmodule

// ==== test/dmfc_codec_chk.sv ====
`timescale 1ns/1ps

// ********************
// Stream, filter and register side checks
// ********************
module dmfc_codec_chk
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic tx_ready,
    input wire logic pkt_valid,
    input wire logic pkt_is_udp,
    input wire logic pkt_match,
    input wire logic scan_start,
    input wire logic [7:0] channel_map_selector,
    input wire logic basic_mode
);
    logic [4:0] n_byte;
    logic wr_addr;

    // Write address phase, two edges before the register moves
    assign wr_addr = hsel && htrans[1] && hready && hwrite;

    // Byte position inside the current frame
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            n_byte <= 5'h00;
        else if (tx_valid && tx_ready)
            n_byte <= tx_last ? 5'h00 : n_byte + 5'h01;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
        else $error("byte withdrawn");
    a_byte_hold: assert property
        (tx_valid && !tx_ready |=> $stable(tx_data))
        else $error("byte moved");
    a_frame_len: assert property
        (tx_valid && tx_ready && tx_last |->
        n_byte inside {5'h04, 5'h05, 5'h17})
        else $error("bad length");
    a_frame_ends: assert property
        (tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("runs past last");
    a_udp_only: assert property
        (!(pkt_valid && pkt_is_udp) |=> !pkt_match)
        else $error("match without udp");
    a_scan_single: assert property (scan_start |=> !scan_start)
        else $error("scan pulse too long");
    a_map_write: assert property
        ($changed(channel_map_selector) |-> $past(wr_addr, 2))
        else $error("map moved unwritten");
    a_basic_write: assert property
        ($rose(basic_mode) |-> $past(wr_addr, 2))
        else $error("basic without request");
endmodule

bind dmfc_codec dmfc_codec_chk dmfc_codec_chk_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .pkt_valid(pkt_valid),
    .pkt_is_udp(pkt_is_udp), .pkt_match(pkt_match),
    .scan_start(scan_start), .basic_mode(basic_mode),
    .channel_map_selector(channel_map_selector));

// ==== test/dmfc_card_sink.sv ====
`timescale 1ns/1ps

// ********************
// Card side byte sink
// ********************
module dmfc_card_sink
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic slow,
    output logic tx_ready
);
    logic [7:0] got[$];

    // Slow card stalls at random, so held bytes get exercised
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_ready <= 1'b1;
        else
        begin
            if (tx_valid && tx_ready)
                got.push_back(tx_data);
            tx_ready <= !slow || ($urandom % 3 == 0);
        end
    end
endmodule

// ==== test/dmfc_codec_tb_top.sv ====
`timescale 1ns/1ps
`include "dmfc_defines.svh"

// ********************
// Bench top
// ********************
module dmfc_codec_tb_top import dmfc_pkg::*;;
    localparam int SC = 4;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow, adv;
    logic [31:0] haddr, hwdata, hrdata, v, rsrc, rmsk, rdst;
    logic [1:0] htrans;
    logic [7:0] tx_data, match_tunnel, channel_map_selector, ucn;
    logic tx_valid, tx_last, tx_ready, op_timeout, scan_start, em;
    logic pkt_valid, pkt_is_udp, pkt_match, basic_mode;
    logic [47:0] pkt_mac, rmac;
    logic [31:0] pkt_src_ip, pkt_dst_ip;
    logic [15:0] pkt_dst_port, ps, pe;
    logic [191:0] rec;
    logic [7:0] exp_q[$];
    int n_fail, tests_run, n;

    dmfc_codec #(.SEC_CYCLES(SC)) dmfc_codec_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready), .op_timeout(op_timeout),
        .scan_start(scan_start), .pkt_valid(pkt_valid),
        .pkt_is_udp(pkt_is_udp), .pkt_mac(pkt_mac),
        .pkt_src_ip(pkt_src_ip), .pkt_dst_ip(pkt_dst_ip),
        .pkt_dst_port(pkt_dst_port), .pkt_match(pkt_match),
        .match_tunnel(match_tunnel), .basic_mode(basic_mode),
        .channel_map_selector(channel_map_selector));
    dmfc_card_sink dmfc_card_sink_i (.hclk(hclk), .hresetn(hresetn),
        .tx_data(tx_data), .tx_valid(tx_valid), .slow(slow),
        .tx_ready(tx_ready));

    task chk(input logic [47:0] got, input logic [47:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task final_report;
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Address phase held until ready, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    // Expected bytes, then a margin for strays
    task drain;
        for (int i = 0; i < 400 &&
            dmfc_card_sink_i.got.size() < exp_q.size(); i++)
            @(posedge hclk);
        repeat (12) @(posedge hclk);
        chk(dmfc_card_sink_i.got.size(), exp_q.size());
        foreach (exp_q[i])
            chk(dmfc_card_sink_i.got[i], exp_q[i]);
        exp_q.delete();
        dmfc_card_sink_i.got.delete();
    endtask

    task msg(input logic [7:0] t, input logic [7:0] p);
        em = t == 8'h01 || t == 8'h04 || t == 8'h07;
        if (adv && t >= 8'h01 && t <= 8'h07 && !(t == 8'h04 && p > 8'h05)
            && !(t == 8'h07 && p > 8'h01))
        begin
            exp_q = {8'h9F, 8'h91, 8'h03, em ? 8'h02 : 8'h01, t};
            if (em)
                exp_q.push_back(p);
            if (t == 8'h01)
                ucn = p;
        end
        bus(1'b1, `DMFC_OFS_MSG, {16'h0000, p, t});
        drain();
    endtask

    task setmode(input logic [1:0] m);
        bus(1'b1, `DMFC_OFS_CTRL, {30'h0, m});
        adv = m == 2'h1 || m == 2'h2;
    endtask

    task setrec;
        bus(1'b1, `DMFC_OFS_TUN, {16'h0000, rec[183:176], rec[191:184]});
        bus(1'b1, `DMFC_OFS_MACLO, rmac[31:0]);
        bus(1'b1, `DMFC_OFS_MACHI, {16'h0000, rmac[47:32]});
        bus(1'b1, `DMFC_OFS_SRCIP, rsrc);
        bus(1'b1, `DMFC_OFS_SRCMSK, rmsk);
        bus(1'b1, `DMFC_OFS_DSTIP, rdst);
        bus(1'b1, `DMFC_OFS_PORTS, {ps, pe});
    endtask

    // Pulse the timeout, count cycles to the scan pulse
    task scan(input logic [15:0] tv);
        bus(1'b1, `DMFC_OFS_TIMER, {8'h00, ucn, tv});
        @(posedge hclk);
        chk(channel_map_selector, ucn);
        op_timeout <= 1'b1;
        @(posedge hclk);
        op_timeout <= 1'b0;
        for (n = 0; n < 60 && scan_start !== 1'b1; n++)
            @(posedge hclk);
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial
    begin
        #(4 * 40000);
        n_fail++;
        final_report();
    end

    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, slow, adv} = '0;
        {op_timeout, pkt_valid, pkt_is_udp, pkt_mac, ucn} = '0;
        {pkt_src_ip, pkt_dst_ip, pkt_dst_port} = '0;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(32'h2213));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `DMFC_OFS_SRCMSK, 32'h0);
        chk(v, 32'hFFFFFFFF);
        bus(1'b0, 8'h3C, 32'h0);
        chk({hresp, v}, 33'h0);
        msg(8'h02, 8'h00);
        setmode(2'h1);
        for (int t = 0; t < 9; t++)
            msg(t[7:0], 8'($urandom % 7));
        msg(8'h04, 8'h06);
        msg(8'h07, 8'h02);
        msg(8'h01, 8'($urandom));
        bus(1'b0, `DMFC_OFS_UCN, 32'h0);
        chk(v[7:0], ucn);
        bus(1'b1, `DMFC_OFS_CTRL, 32'h00000095);
        exp_q = {8'h9F, 8'h91, 8'h03, 8'h01, 8'h06};
        drain();
        chk(basic_mode, 1'b0);
        bus(1'b1, `DMFC_OFS_CTRL, 32'h00000085);
        repeat (2) @(posedge hclk);
        chk(basic_mode, 1'b1);
        setmode(2'h3);
        msg(8'h01, 8'h05);
        for (int i = 0; i < 24; i++)
        begin
            {rec, rmac} = {$urandom, $urandom, $urandom, $urandom, $urandom,
                $urandom, $urandom, $urandom};
            rsrc = (i % 3 == 0) ? 32'h0 : $urandom;
            rmsk = (i % 2 == 1) ? 32'hFFFFFFFF : $urandom;
            rdst = (i % 4 == 0) ? 32'h0 : $urandom;
            ps = 16'($urandom);
            pe = ps + 16'($urandom % 64);
            setrec();
            @(posedge hclk);
            pkt_valid <= 1'b1;
            pkt_is_udp <= i % 7 != 6;
            pkt_mac <= (i % 5 == 4) ? rmac ^ 48'h1 : rmac;
            pkt_src_ip <= (i % 2 == 0) ? (rsrc & rmsk) | (~rmsk & $urandom)
                : $urandom;
            pkt_dst_ip <= (i % 4 == 1) ? $urandom : rdst;
            pkt_dst_port <= ps + 16'($urandom % 80) - 16'h0008;
            @(posedge hclk);
            pkt_valid <= 1'b0;
            #1;
            chk(pkt_match, pkt_mac == rmac && pkt_is_udp
                && (rsrc == 0 || ((pkt_src_ip ^ rsrc) & rmsk) == 0)
                && (rdst == 0 || pkt_dst_ip == rdst)
                && pkt_dst_port >= ps && pkt_dst_port <= pe);
        end
        rec = {rec[191:176], rmac, rsrc, rmsk, rdst, ps, pe};
        slow <= 1'b1;
        for (int i = 0; i < 24; i++)
            exp_q.push_back(rec[191 - 8 * i -: 8]);
        bus(1'b1, `DMFC_OFS_MSG, 32'h00010000);
        drain();
        chk(match_tunnel, rec[191:184]);
        scan(16'h0000);
        chk(n, 32'h1);
        scan(16'h0002);
        chk(n >= 2 * SC && n <= 2 * SC + 2, 1'b1);
        final_report();
    end
endmodule
